// [hdl/gpio_consts.svh]
// offsets, field positions and reset values of the pin port
// assumes inclusion by every design file of the port
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ==========================================
// register offsets
`define OFS_PIN_DATA   4'h0
`define OFS_DIRECTION  4'h1
`define OFS_ANALOG     4'h2
`define OFS_PULLUP     4'h3
`define OFS_OPTION     4'h4
`define OFS_CHG_EN     4'h5
`define OFS_INT_CTRL   4'h6
`define OFS_ALT_SEL    4'h7
`define OFS_PIN_SET    4'h8
`define OFS_PIN_CLR    4'h9

// ==========================================
// field positions
`define BIT_GLOBAL_PU_DIS 7
`define BIT_CHG_FLAG      0
`define BIT_CHG_IE        1
`define BIT_ROUTE_C_ONE   0
`define PIN_CCP_INDEX     3

// ==========================================
// reset values
`define RST_LATCH      8'h00
`define RST_DIRECTION  8'hff
`define RST_ANALOG     8'hff
`define RST_PULLUP     8'hff
`define RST_OPTION     8'hff
`define RST_CHG_EN     8'h00
`define RST_LAST_VALUE 8'h00
`define RST_RDATA      8'h00

`endif

// [hdl/gpio_pkg.sv]
// types shared by the pin port modules
// assumes the constants header is compiled alongside
package gpio_pkg;

   // ==========================================
   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // ==========================================
   // capture/compare two pin drive
   typedef struct packed {
      logic val;
      logic oe;
   } alt_drive_t;

endpackage

// [hdl/pin_cell.sv]
// one pad of the port: driver, pull-up and digital read path
// assumes pad input synchronous to the core clock
module pin_cell (
   // configuration
   input  wire logic dir,
   input  wire logic analog,
   input  wire logic pu_en,
   input  wire logic pu_gdis,
   input  wire logic latch,
   // alternate drive
   input  wire logic alt_en,
   input  wire logic alt_val,
   // pad
   input  wire logic pad_in,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pu_on,
   output logic      rd_val
);

   // ==========================================
   // driver
   assign pad_oe  = ~dir;
   assign pad_out = alt_en ? alt_val : latch;

   // ==========================================
   // pull-up and read path
   assign pu_on  = pu_en & dir & ~pu_gdis;
   assign rd_val = pad_in & ~analog;

endmodule

// [hdl/change_detect.sv]
// last-value latch and mismatch compare for change detection
// assumes only power-on reset may clear the last-value latch
module change_detect #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         por,
   // compare
   input  wire logic [W-1:0] pin_val,
   input  wire logic [W-1:0] enable,
   input  wire logic         reload,
   output logic [W-1:0]      mismatch,
   output logic              any
);

   logic [W-1:0] last_reg;

   // ==========================================
   // last-value latch, kept over all other resets
   always_ff @(posedge clk) begin
      if (por) begin
         last_reg <= '0;
      end else if (reload) begin
         last_reg <= pin_val;
      end
   end

   // ==========================================
   // compare
   assign mismatch = (pin_val ^ last_reg) & enable;
   assign any      = |mismatch;

   // ==========================================
   // checks
   last_keep_a : assert property (
      @(posedge clk) disable iff (por)
      !reload |=> $stable(last_reg))
      else $error("last value latch changed without port access");

   last_load_a : assert property (
      @(posedge clk) disable iff (por)
      reload |=> last_reg == $past(pin_val))
      else $error("last value latch not reloaded on port access");

endmodule

// [hdl/bidir_port_pullup_ioc.sv]
// eight pin bidirectional port with pull-ups and change detection
// assumes synchronous pins and a single-cycle register port master
//
// Contract
// - eight pins, each with direction bit
// - direction one: driver off, pin input
// - direction zero: drive output latch onto pin
// - data read gives pins, write sets latch
// - set and clear port writes sample pins, modify, store
// - direction controls drivers even for analog
// - analog pins read zero digitally
// - analog select never changes digital output
// - per-pin weak pull-up enable bits
// - pull-up forced off on output pins
// - power-on reset disables all pull-ups globally
// - change enables cleared by power-on reset
// - enabled pins compared to last value
// - ORed mismatches set change flag
// - change interrupt can wake device
// - port access reloads latch, ends mismatch
// - persisting mismatch keeps setting flag
// - last value survives non power-on resets
// - change during read still sets flag
// - capture/compare two routable to two pins
`include "gpio_consts.svh"

module bidir_port_pullup_ioc #(
   parameter int W = 8
) (
   // clock and resets
   input  wire logic              CORE_CLK,
   input  wire logic              RST,
   input  wire logic              POR,
   // register port
   input  wire gpio_pkg::reg_req_t REG_REQ,
   output logic [7:0]             REG_RDATA,
   // port pins
   input  wire logic [W-1:0]      PIN_DATA_IN,
   output logic [W-1:0]           PIN_DATA_OUT,
   output logic [W-1:0]           PIN_DATA_OE,
   output logic [W-1:0]           PIN_PULLUP,
   // change event
   output logic                   CHANGE_IRQ_FLAG,
   output logic                   WAKE,
   // capture/compare two
   input  wire logic              CCP_TWO_OUT,
   input  wire logic              CCP_TWO_OE,
   output logic                   CCP_TWO_IN,
   input  wire logic              PIN_C_ONE_IN,
   output logic                   PIN_C_ONE_OUT,
   output logic                   PIN_C_ONE_OE
);
   import gpio_pkg::*;

   // ==========================================
   // state
   logic [W-1:0] latch_reg;
   logic [W-1:0] latch_next;
   logic [W-1:0] direction_reg;
   logic [W-1:0] analog_select_reg;
   logic [W-1:0] pullup_enable_reg;
   logic [7:0]   option_reg;
   logic [W-1:0] change_irq_enable_reg;
   logic         change_irq_flag_reg;
   logic         change_irq_flag_next;
   logic         flag_ie_reg;
   logic         route_reg;
   logic [7:0]   rdata_reg;
   logic [7:0]   rdata_next;

   // ==========================================
   // decode
   logic         any_rst;
   logic         wr_data;
   logic         wr_set;
   logic         wr_clr;
   logic         wr_dir;
   logic         wr_ana;
   logic         wr_pu;
   logic         wr_opt;
   logic         wr_chg;
   logic         wr_int;
   logic         wr_alt;
   logic         rd_data;
   logic         port_addr;
   logic         port_access;
   logic         clear_try;

   assign any_rst   = RST | POR;
   assign wr_data   = REG_REQ.wr && (REG_REQ.addr == `OFS_PIN_DATA);
   assign wr_set    = REG_REQ.wr && (REG_REQ.addr == `OFS_PIN_SET);
   assign wr_clr    = REG_REQ.wr && (REG_REQ.addr == `OFS_PIN_CLR);
   assign wr_dir    = REG_REQ.wr && (REG_REQ.addr == `OFS_DIRECTION);
   assign wr_ana    = REG_REQ.wr && (REG_REQ.addr == `OFS_ANALOG);
   assign wr_pu     = REG_REQ.wr && (REG_REQ.addr == `OFS_PULLUP);
   assign wr_opt    = REG_REQ.wr && (REG_REQ.addr == `OFS_OPTION);
   assign wr_chg    = REG_REQ.wr && (REG_REQ.addr == `OFS_CHG_EN);
   assign wr_int    = REG_REQ.wr && (REG_REQ.addr == `OFS_INT_CTRL);
   assign wr_alt    = REG_REQ.wr && (REG_REQ.addr == `OFS_ALT_SEL);
   assign rd_data   = REG_REQ.rd && (REG_REQ.addr == `OFS_PIN_DATA);

   assign port_addr = (REG_REQ.addr == `OFS_PIN_DATA) ||
                      (REG_REQ.addr == `OFS_PIN_SET)  ||
                      (REG_REQ.addr == `OFS_PIN_CLR);
   assign port_access = (REG_REQ.wr | REG_REQ.rd) & port_addr;
   assign clear_try   = wr_int && !REG_REQ.wdata[`BIT_CHG_FLAG];

   // ==========================================
   // pin cells
   logic [W-1:0] pin_rd;
   logic [W-1:0] alt_mask;
   alt_drive_t   ccp_drive;

   assign ccp_drive.val = CCP_TWO_OUT;
   assign ccp_drive.oe  = CCP_TWO_OE;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         assign alt_mask[i] = (i == `PIN_CCP_INDEX) && !route_reg && ccp_drive.oe;
         pin_cell u_cell (
            .dir     (direction_reg[i]),
            .analog  (analog_select_reg[i]),
            .pu_en   (pullup_enable_reg[i]),
            .pu_gdis (option_reg[`BIT_GLOBAL_PU_DIS]),
            .latch   (latch_reg[i]),
            .alt_en  (alt_mask[i]),
            .alt_val (ccp_drive.val),
            .pad_in  (PIN_DATA_IN[i]),
            .pad_out (PIN_DATA_OUT[i]),
            .pad_oe  (PIN_DATA_OE[i]),
            .pu_on   (PIN_PULLUP[i]),
            .rd_val  (pin_rd[i])
         );
      end
   endgenerate

   // ==========================================
   // capture/compare two routing
   assign CCP_TWO_IN    = route_reg ? PIN_C_ONE_IN : PIN_DATA_IN[`PIN_CCP_INDEX];
   assign PIN_C_ONE_OUT = ccp_drive.val;
   assign PIN_C_ONE_OE  = route_reg & ccp_drive.oe;

   // ==========================================
   // output latch
   always_comb begin
      latch_next = latch_reg;
      if (wr_data) begin
         latch_next = REG_REQ.wdata[W-1:0];
      end else if (wr_set) begin
         latch_next = pin_rd | REG_REQ.wdata[W-1:0];
      end else if (wr_clr) begin
         latch_next = pin_rd & ~REG_REQ.wdata[W-1:0];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         latch_reg <= `RST_LATCH;
      end else begin
         latch_reg <= latch_next;
      end
   end

   // ==========================================
   // configuration registers
   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         direction_reg     <= `RST_DIRECTION;
         analog_select_reg <= `RST_ANALOG;
         pullup_enable_reg <= `RST_PULLUP;
         option_reg        <= `RST_OPTION;
      end else begin
         if (wr_dir) begin
            direction_reg <= REG_REQ.wdata[W-1:0];
         end
         if (wr_ana) begin
            analog_select_reg <= REG_REQ.wdata[W-1:0];
         end
         if (wr_pu) begin
            pullup_enable_reg <= REG_REQ.wdata[W-1:0];
         end
         if (wr_opt) begin
            option_reg <= REG_REQ.wdata;
         end
      end
   end

   // change enables are left alone by the non power-on reset
   always_ff @(posedge CORE_CLK) begin
      if (POR) begin
         change_irq_enable_reg <= `RST_CHG_EN;
      end else if (wr_chg) begin
         change_irq_enable_reg <= REG_REQ.wdata[W-1:0];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         flag_ie_reg <= 1'b0;
         route_reg   <= 1'b0;
      end else begin
         if (wr_int) begin
            flag_ie_reg <= REG_REQ.wdata[`BIT_CHG_IE];
         end
         if (wr_alt) begin
            route_reg <= REG_REQ.wdata[`BIT_ROUTE_C_ONE];
         end
      end
   end

   // ==========================================
   // change detection
   logic [W-1:0] mismatch;
   logic         mismatch_any;

   change_detect #(
      .W (W)
   ) u_change (
      .clk      (CORE_CLK),
      .por      (POR),
      .pin_val  (pin_rd),
      .enable   (change_irq_enable_reg),
      .reload   (port_access),
      .mismatch (mismatch),
      .any      (mismatch_any)
   );

   always_comb begin
      change_irq_flag_next = change_irq_flag_reg;
      if (mismatch_any) begin
         change_irq_flag_next = 1'b1;
      end else if (wr_int) begin
         change_irq_flag_next = REG_REQ.wdata[`BIT_CHG_FLAG];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         change_irq_flag_reg <= 1'b0;
      end else begin
         change_irq_flag_reg <= change_irq_flag_next;
      end
   end

   assign CHANGE_IRQ_FLAG = change_irq_flag_reg;
   assign WAKE            = change_irq_flag_reg & flag_ie_reg;

   // ==========================================
   // read data
   always_comb begin
      rdata_next = `RST_RDATA;
      case (REG_REQ.addr)
         `OFS_PIN_DATA,
         `OFS_PIN_SET,
         `OFS_PIN_CLR: begin
            rdata_next = pin_rd;
         end
         `OFS_DIRECTION: begin
            rdata_next = direction_reg;
         end
         `OFS_ANALOG: begin
            rdata_next = analog_select_reg;
         end
         `OFS_PULLUP: begin
            rdata_next = pullup_enable_reg;
         end
         `OFS_OPTION: begin
            rdata_next = option_reg;
         end
         `OFS_CHG_EN: begin
            rdata_next = change_irq_enable_reg;
         end
         `OFS_INT_CTRL: begin
            rdata_next[`BIT_CHG_FLAG] = change_irq_flag_reg;
            rdata_next[`BIT_CHG_IE]   = flag_ie_reg;
         end
         `OFS_ALT_SEL: begin
            rdata_next[`BIT_ROUTE_C_ONE] = route_reg;
         end
         default: begin
            rdata_next = `RST_RDATA;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         rdata_reg <= `RST_RDATA;
      end else if (REG_REQ.rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= `RST_RDATA;
      end
   end

   assign REG_RDATA = rdata_reg;

   // ==========================================
   // checks
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (any_rst);

   sequence port_touch_s;
      port_access ##1 ($stable(PIN_DATA_IN) && $stable(analog_select_reg));
   endsequence

   sequence clear_attempt_s;
      mismatch_any && clear_try;
   endsequence

   tristate_dir_a : assert property (
      (PIN_DATA_OE & direction_reg) == '0)
      else $error("driver on for input pin");

   drive_latch_a : assert property (
      ((PIN_DATA_OUT ^ latch_reg) & ~direction_reg & ~alt_mask) == '0 &&
      (PIN_DATA_OE | direction_reg) == '1)
      else $error("output pin not driving latch");

   read_pins_a : assert property (
      rd_data |=> REG_RDATA == $past(pin_rd))
      else $error("port read does not return pins");

   write_latch_a : assert property (
      wr_data |=> latch_reg == $past(REG_REQ.wdata))
      else $error("port write did not load latch");

   rmw_set_a : assert property (
      wr_set |=> latch_reg == ($past(pin_rd) | $past(REG_REQ.wdata)))
      else $error("set write not read-modify-write");

   analog_zero_a : assert property (
      (pin_rd & analog_select_reg) == '0)
      else $error("analog pin reads nonzero");

   pullup_off_a : assert property (
      (PIN_PULLUP & ~direction_reg) == '0)
      else $error("pull-up on output pin");

   por_pullup_a : assert property (
      $fell(POR) |-> option_reg[`BIT_GLOBAL_PU_DIS] && PIN_PULLUP == '0)
      else $error("pull-ups not disabled after power-on");

   por_change_a : assert property (
      $fell(POR) |-> change_irq_enable_reg == '0)
      else $error("change enables not cleared at power-on");

   flag_set_a : assert property (
      mismatch_any |=> CHANGE_IRQ_FLAG)
      else $error("mismatch did not set change flag");

   persist_flag_a : assert property (
      clear_attempt_s |=> CHANGE_IRQ_FLAG)
      else $error("clear won over persisting mismatch");

   access_reload_a : assert property (
      port_touch_s |-> mismatch == '0)
      else $error("port access did not end mismatch");

   same_cycle_a : assert property (
      port_access && mismatch_any |=> CHANGE_IRQ_FLAG)
      else $error("change during port access lost");

   flag_clear_a : assert property (
      !mismatch_any && clear_try |=> !CHANGE_IRQ_FLAG)
      else $error("zero write did not clear flag");

   wake_a : assert property (
      CHANGE_IRQ_FLAG && flag_ie_reg |-> WAKE)
      else $error("change flag did not wake");

   route_a : assert property (
      route_reg |-> CCP_TWO_IN == PIN_C_ONE_IN && alt_mask == '0)
      else $error("capture/compare two misrouted");

endmodule

// [sim/pin_world.sv]
// outside circuitry on the eight pads: drivers, pull-ups, floating pins
// assumes the port drives a pad only while its enable is high
module pin_world (
   // clock
   input  wire logic       clk,
   // port side
   input  wire logic [7:0] drv_out,
   input  wire logic [7:0] drv_oe,
   input  wire logic [7:0] pu_on,
   // outside drivers
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   // resolved pads
   output logic [7:0]      pad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last_reg;

   // ==========================================
   // pad level: port, then outside, then pull-up, else floating
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (drv_oe[i])
            pad[i] = drv_out[i];
         else if (ext_en[i])
            pad[i] = ext_val[i];
         else if (pu_on[i])
            pad[i] = 1'b1;
         else
            pad[i] = ~last_reg[i];
      end
   end

   // floating pins wander away from their last level
   always_ff @(posedge clk) begin
      last_reg <= pad;
   end
endmodule

// [sim/bidir_port_pullup_ioc_bench.sv]
// register-level bench of the eight pin port
// assumes the pin world model on the pads and a single bus master
`include "gpio_consts.svh"

module bidir_port_pullup_ioc_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import gpio_pkg::*;

   logic       clk, rst, por, flag, wake, ccp_out, ccp_oe, ccp_in;
   logic       c1_in, c1_out, c1_oe;
   reg_req_t   req;
   logic [7:0] rdata, pout, poe, ppu, pad, ext_en, ext_val, v;
   logic [7:0] rv [8];
   int         err_count, checks;

   // ==========================================
   // design and outside world
   bidir_port_pullup_ioc u_dut (
      .CORE_CLK(clk), .RST(rst), .POR(por), .REG_REQ(req), .REG_RDATA(rdata),
      .PIN_DATA_IN(pad), .PIN_DATA_OUT(pout), .PIN_DATA_OE(poe), .PIN_PULLUP(ppu),
      .CHANGE_IRQ_FLAG(flag), .WAKE(wake), .CCP_TWO_OUT(ccp_out),
      .CCP_TWO_OE(ccp_oe), .CCP_TWO_IN(ccp_in), .PIN_C_ONE_IN(c1_in),
      .PIN_C_ONE_OUT(c1_out), .PIN_C_ONE_OE(c1_oe)
   );

   pin_world u_world (
      .clk(clk), .drv_out(pout), .drv_oe(poe), .pu_on(ppu),
      .ext_en(ext_en), .ext_val(ext_val), .pad(pad)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================
   // bus and check tasks
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task acc(input logic [3:0] a, input logic [7:0] d, input logic w);
      req <= '{a, d, w, ~w};
      cyc(1);
      v = rdata;
      req <= '0;
      cyc(1);
   endtask

   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", n, e, g);
      end
   endtask

   task end_sim;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_sim();
   end

   // ==========================================
   // scenarios
   initial begin
      rst = 1'b1; por = 1'b1; req = '0; ext_en = 8'hff; ext_val = 8'ha5;
      ccp_out = 1'b0; ccp_oe = 1'b0; c1_in = 1'b0; err_count = 0; checks = 0;
      rv = '{8'h00, `RST_DIRECTION, `RST_ANALOG, `RST_PULLUP, `RST_OPTION,
             `RST_CHG_EN, 8'h00, 8'h00};
      cyc(20);
      rst <= 1'b0;
      por <= 1'b0;
      cyc(1);
      // reset state and unmapped place
      chk("oe rst", 8'h00, poe);
      chk("pull rst", 8'h00, ppu);
      for (int i = 1; i < 8; i++) begin
         acc(4'(i), 8'h00, 1'b0);
         chk("reset val", rv[i], v);
      end
      acc(4'ha, 8'h00, 1'b0);
      chk("unmapped", 8'h00, v);
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      chk("analog rd", 8'h00, v);
      // pins, pull-ups, directions
      acc(`OFS_ANALOG, 8'h00, 1'b1);
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      chk("pins", 8'ha5, v);
      acc(`OFS_OPTION, 8'h00, 1'b1);
      acc(`OFS_PULLUP, 8'h3c, 1'b1);
      chk("pull sel", 8'h3c, ppu);
      acc(`OFS_DIRECTION, 8'h0f, 1'b1);
      chk("oe dir", 8'hf0, poe);
      chk("pull out", 8'h0c, ppu);
      ext_en <= 8'hf3;
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      chk("pull pad", 8'h0d, v);
      ext_en <= 8'hff;
      acc(`OFS_PIN_DATA, 8'h3c, 1'b1);
      chk("latch", 8'h3c, pout);
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      chk("mixed rd", 8'h35, v);
      // read-modify-write
      acc(`OFS_PIN_SET, 8'h80, 1'b1);
      chk("pin set", 8'hb5, pout);
      acc(`OFS_PIN_CLR, 8'h30, 1'b1);
      chk("pin clr", 8'h85, pout);
      // analog select on driven pins
      acc(`OFS_ANALOG, 8'hf0, 1'b1);
      chk("analog out", 8'h85, pout);
      chk("analog oe", 8'hf0, poe);
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      chk("analog mix", 8'h05, v);
      // change detection
      acc(`OFS_ANALOG, 8'h00, 1'b1);
      acc(`OFS_DIRECTION, 8'hff, 1'b1);
      ext_val <= 8'h00;
      acc(`OFS_CHG_EN, 8'hff, 1'b1);
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      acc(`OFS_INT_CTRL, 8'h02, 1'b1);
      chk("flag idle", 8'h00, {7'h0, flag});
      ext_val <= 8'h01;
      cyc(1);
      chk("flag set", 8'h01, {7'h0, flag});
      acc(`OFS_INT_CTRL, 8'h02, 1'b1);
      chk("flag held", 8'h01, {7'h0, flag});
      chk("wake", 8'h01, {7'h0, wake});
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      acc(`OFS_INT_CTRL, 8'h02, 1'b1);
      chk("flag clr", 8'h00, {6'h0, wake, flag});
      ext_val <= 8'h03;
      acc(`OFS_PIN_DATA, 8'h00, 1'b0);
      chk("race", 8'h01, {7'h0, flag});
      acc(`OFS_INT_CTRL, 8'h02, 1'b1);
      chk("race clr", 8'h00, {7'h0, flag});
      acc(`OFS_INT_CTRL, 8'h03, 1'b1);
      chk("flag sw set", 8'h01, {7'h0, flag});
      // other reset keeps last value and enables
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(2);
      chk("rst flag", 8'h01, {7'h0, flag});
      chk("rst wake", 8'h00, {7'h0, wake});
      acc(`OFS_CHG_EN, 8'h00, 1'b0);
      chk("rst ien", 8'hff, v);
      por <= 1'b1;
      cyc(1);
      por <= 1'b0;
      cyc(1);
      acc(`OFS_CHG_EN, 8'h00, 1'b0);
      chk("por ien", 8'h00, v);
      chk("por flag", 8'h00, {7'h0, flag});
      // capture/compare two routing
      acc(`OFS_ANALOG, 8'h00, 1'b1);
      acc(`OFS_DIRECTION, 8'hf7, 1'b1);
      ccp_oe <= 1'b1;
      ccp_out <= 1'b1;
      cyc(1);
      chk("ccp b3", 8'h08, pout);
      chk("ccp b3 in", 8'h01, {6'h0, c1_oe, ccp_in});
      c1_in <= 1'b1;
      acc(`OFS_ALT_SEL, 8'h01, 1'b1);
      chk("ccp c1", 8'h07, {5'h0, c1_oe, c1_out, ccp_in});
      chk("b3 free", 8'h00, pout);
      end_sim();
   end
endmodule
